// ### rtl/pcc_pkg.sv
// pcc_pkg: constants and types for the card controller host port.
// assumes: a 32-bit processor address, 16-bit multiplexed card bus.
package pcc_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned PCC_CLK_MHZ = 100;
    localparam int unsigned PCC_CARD_CLK_MHZ = 18;
    // core cycles per card bus phase, rounded down, never below one
    localparam int unsigned PCC_PHASE_CYC_RAW = PCC_CLK_MHZ / PCC_CARD_CLK_MHZ;
    localparam logic [3:0] PCC_PHASE_CYC = (PCC_PHASE_CYC_RAW < 1) ? 4'h1 : 4'(PCC_PHASE_CYC_RAW);

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [3:0] PCC_REGION_ONE = 4'h4;
    localparam logic [3:0] PCC_REGION_TWO = 4'h5;
    localparam int unsigned PCC_REGION_LSB = 28;
    localparam int unsigned PCC_SPACE_LSB = 26;
    localparam int unsigned PCC_CARD_ADDR_W = 26;

    // ------------------------------------------------------------
    // field encodings
    // ------------------------------------------------------------
    localparam logic [1:0] PCC_SPACE_ATTR = 2'h0;
    localparam logic [1:0] PCC_SPACE_IO = 2'h1;
    localparam logic [1:0] PCC_SPACE_COMMON = 2'h2;
    localparam logic [1:0] PCC_SPACE_REGS = 2'h3;
    localparam logic [1:0] PCC_SIZE_WORD = 2'h3;
    localparam logic [1:0] PCC_SIZE_BYTE = 2'h0;
    localparam logic [1:0] PCC_SLOT_FIXED = 2'h3;
    localparam int unsigned PCC_EN_ONE_BIT = 5;
    localparam int unsigned PCC_EN_TWO_BIT = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PCC_BUS_RST = 16'h0000;
    localparam logic PCC_WRITE_IDLE = 1'h0;

    typedef enum logic [2:0] {
        PCC_IDLE,
        PCC_FIELD,
        PCC_ADDR,
        PCC_DATA_HI,
        PCC_DATA_LO,
        PCC_WAIT,
        PCC_DONE
    } pcc_state_t;

endpackage : pcc_pkg

// ### rtl/pcc_sync.sv
// pcc_sync: three-stage synchroniser with agreement of the last two stages.
// assumes: one clock, asynchronous active-low reset, clock enable.
`timescale 1ns/1ps
module pcc_sync (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic async_i,
    output logic level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } pcc_sync_t;

    pcc_sync_t q, d;

    always_comb begin
        d = q;
        d.s1 = async_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.lvl = q.s3;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign level_o = q.lvl;
endmodule : pcc_sync

// ### rtl/pcc_host_port.sv
// pcc_host_port: processor-side port that reaches two card controllers over
// the lower 16 data lines, address and data multiplexed in time.
// assumes: processor holds its request until done_o; ready pins are async.
//
// Summary of operation
// - card regions live only when enable bit set
// - address and data on lower 16 lines
// - access in either region starts transaction, selects chip
// - four 64MB segments, bases 0x4 and 0x5
// - port meant for 18 MHz card clock only
// - first phase: top 10 address, size/space/slot
// - only word and byte transfers accepted
// - slot field always binary 11
// - space field from address bits 26, 27
// - space: attribute, io, common, controller registers
// - size 11 for word, 00 for byte
// - second phase: low 16 card address bits
// - word transfer: two data halfwords, byte transfer: one
// - write pin low write, high read, phase one
// - write pin forced high in phase two
// - port B bit becomes ready when enabled
// - ready low, except register space: stall, drop select, release bus
`timescale 1ns/1ps
module pcc_host_port
    import pcc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [6:0] system_config_two_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_byte_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [31:0] req_wdata_i,
    output logic done_o,
    output logic refused_o,
    output logic stall_o,
    output logic [31:0] rdata_o,
    output logic card_select_first_n_o,
    output logic card_select_second_n_o,
    output logic write_o,
    output logic [15:0] bus_o,
    output logic bus_oe_n_o,
    input wire logic [15:0] bus_i,
    input wire logic [1:0] port_b_i,
    output logic [1:0] card_controller_ready_o,
    output logic [1:0] port_b_gpio_o
);
    typedef struct packed {
        pcc_state_t st;
        logic [3:0] cnt;
        logic slot;
        logic wr;
        logic byte_sz;
        logic [1:0] space;
        logic [25:0] addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic done;
        logic refused;
        logic stall;
        logic sel1_n;
        logic sel2_n;
        logic write;
        logic [15:0] bus;
        logic oe_n;
        logic [1:0] rdy;
        logic [1:0] gpio;
    } pcc_host_t;

    pcc_host_t q, d;
    logic [1:0] pin_lvl;
    logic hit1;
    logic hit2;
    logic ready_sel;
    logic phase_end;

    // ------------------------------------------------------------
    // ready pin synchronisers
    // ------------------------------------------------------------
    for (genvar g = 0; g < 2; g++) begin : g_sync
        pcc_sync u_sync (
            .core_clk_i(core_clk_i),
            .rst_n_i(rst_n_i),
            .clk_en_i(clk_en_i),
            .async_i(port_b_i[g]),
            .level_o(pin_lvl[g])
        );
    end

    function automatic logic region_hit(input logic [31:0] a, input logic [3:0] base, input logic en);
        region_hit = en && (a[31:PCC_REGION_LSB] == base);
    endfunction : region_hit

    // ------------------------------------------------------------
    // transaction sequencer
    // ------------------------------------------------------------
    always_comb begin
        hit1 = region_hit(req_addr_i, PCC_REGION_ONE, system_config_two_i[PCC_EN_ONE_BIT]);
        hit2 = region_hit(req_addr_i, PCC_REGION_TWO, system_config_two_i[PCC_EN_TWO_BIT]);
        ready_sel = q.slot ? pin_lvl[1] : pin_lvl[0];
        phase_end = (q.cnt == PCC_PHASE_CYC - 4'h1);
        d = q;
        d.done = 1'b0;
        d.refused = 1'b0;
        d.rdy[0] = system_config_two_i[PCC_EN_ONE_BIT] ? pin_lvl[0] : 1'b1;
        d.rdy[1] = system_config_two_i[PCC_EN_TWO_BIT] ? pin_lvl[1] : 1'b1;
        d.gpio[0] = system_config_two_i[PCC_EN_ONE_BIT] ? 1'b0 : pin_lvl[0];
        d.gpio[1] = system_config_two_i[PCC_EN_TWO_BIT] ? 1'b0 : pin_lvl[1];
        if (q.st != PCC_IDLE && q.st != PCC_WAIT && q.st != PCC_DONE) begin
            d.cnt = phase_end ? 4'h0 : q.cnt + 4'h1;
        end
        case (q.st)
            PCC_IDLE: begin
                d.cnt = 4'h0;
                if (req_i && (hit1 || hit2)) begin
                    d.slot = hit2;
                    d.wr = req_write_i;
                    d.byte_sz = req_byte_i;
                    d.space = req_addr_i[PCC_SPACE_LSB +: 2];
                    d.addr = req_addr_i[PCC_CARD_ADDR_W-1:0];
                    d.wdata = req_wdata_i;
                    d.stall = 1'b1;
                    d.sel1_n = hit2;
                    d.sel2_n = !hit2;
                    d.write = !req_write_i;
                    d.oe_n = 1'b0;
                    d.bus = {req_addr_i[PCC_CARD_ADDR_W-1 -: 10], req_byte_i ? PCC_SIZE_BYTE : PCC_SIZE_WORD,
                             req_addr_i[PCC_SPACE_LSB +: 2], PCC_SLOT_FIXED};
                    d.st = PCC_FIELD;
                end
            end
            PCC_FIELD: begin
                if (phase_end) begin
                    d.bus = q.addr[15:0];
                    d.write = 1'b1;
                    d.st = PCC_ADDR;
                end
            end
            PCC_ADDR: begin
                if (phase_end) begin
                    d.write = !q.wr;
                    if (ready_sel || q.space == PCC_SPACE_REGS) begin
                        d.st = q.byte_sz ? PCC_DATA_LO : PCC_DATA_HI;
                        d.bus = q.byte_sz ? q.wdata[15:0] : q.wdata[31:16];
                        d.oe_n = !q.wr;
                    end else begin
                        d.sel1_n = 1'b1;
                        d.sel2_n = 1'b1;
                        d.oe_n = 1'b1;
                        d.st = PCC_WAIT;
                    end
                end
            end
            PCC_WAIT: begin
                if (ready_sel) begin
                    d.sel1_n = q.slot;
                    d.sel2_n = !q.slot;
                    d.cnt = 4'h0;
                    d.st = q.byte_sz ? PCC_DATA_LO : PCC_DATA_HI;
                    d.bus = q.byte_sz ? q.wdata[15:0] : q.wdata[31:16];
                    d.oe_n = !q.wr;
                end
            end
            PCC_DATA_HI: begin
                if (phase_end) begin
                    if (!q.wr) begin
                        d.rdata[31:16] = bus_i;
                    end
                    d.bus = q.wdata[15:0];
                    d.st = PCC_DATA_LO;
                end
            end
            PCC_DATA_LO: begin
                if (phase_end) begin
                    if (!q.wr) begin
                        d.rdata[15:0] = bus_i;
                        if (q.byte_sz) begin
                            d.rdata[31:16] = 16'h0000;
                        end
                    end
                    d.st = PCC_DONE;
                end
            end
            PCC_DONE: begin
                d.sel1_n = 1'b1;
                d.sel2_n = 1'b1;
                d.oe_n = 1'b1;
                d.bus = PCC_BUS_RST;
                d.write = PCC_WRITE_IDLE;
                d.stall = 1'b0;
                d.done = 1'b1;
                d.st = PCC_IDLE;
            end
            default: begin
                d.st = PCC_IDLE;
            end
        endcase
        if (q.st == PCC_IDLE && req_i && !(hit1 || hit2)) begin
            d.refused = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.st <= PCC_IDLE;
            q.sel1_n <= 1'b1;
            q.sel2_n <= 1'b1;
            q.oe_n <= 1'b1;
            q.rdy <= 2'h3;
        end else if (clk_en_i) begin
            q <= d;
        end
    end

    assign done_o = q.done;
    assign refused_o = q.refused;
    assign stall_o = q.stall;
    assign rdata_o = q.rdata;
    assign card_select_first_n_o = q.sel1_n;
    assign card_select_second_n_o = q.sel2_n;
    assign write_o = q.write;
    assign bus_o = q.bus;
    assign bus_oe_n_o = q.oe_n;
    assign card_controller_ready_o = q.rdy;
    assign port_b_gpio_o = q.gpio;
endmodule : pcc_host_port

// ### verif/pcc_card_model.sv
// pcc_card_model: behavioural card controller facing the host port.
// assumes: same clock as the host port, selects merged by the bench.
`timescale 1ns/1ps
module pcc_card_model (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic sel_n_i,
    input wire logic oe_n_i,
    input wire logic [15:0] host_bus_i,
    output logic [15:0] card_bus_o,
    output logic [1:0] ready_o,
    output logic [15:0] field_o
);
    logic sel_q, used_q, drv;
    logic [4:0] k_q;
    logic [5:0] busy_q;
    logic [15:0] last_q;
    // answer only while selected and the host has let go of the lines
    assign drv = !sel_n_i && oe_n_i;
    assign card_bus_o = drv ? (k_q < 5'h05 ? 16'hA55A : 16'h3C96) : ~last_q;
    assign ready_o = {2{busy_q == 6'h00}};
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_q <= 1'b0;
            used_q <= 1'b0;
            k_q <= 5'h00;
            busy_q <= 6'h00;
            last_q <= 16'h0000;
            field_o <= 16'h0000;
        end else begin
            sel_q <= !sel_n_i;
            // first halfword after a falling select is the field group
            if (!sel_n_i && !sel_q) begin
                field_o <= host_bus_i;
            end
            last_q <= card_bus_o;
            k_q <= oe_n_i ? k_q + {4'h0, drv} : 5'h00;
            used_q <= used_q && slow_i;
            if (busy_q != 6'h00) begin
                busy_q <= busy_q - 6'h01;
            end
            // a falling select opens a transaction; stay busy once if asked
            if (!sel_n_i && !sel_q && slow_i && !used_q) begin
                busy_q <= 6'h1E;
                used_q <= 1'b1;
            end
        end
    end
endmodule : pcc_card_model

// ### verif/pcc_host_port_asserts.sv
// pcc_host_port_asserts: port checks of the card host port.
// assumes: bound to pcc_host_port with clk_en_i held high.
`timescale 1ns/1ps
module pcc_host_port_asserts (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [6:0] system_config_two_i,
    input wire logic req_i,
    input wire logic req_write_i,
    input wire logic req_byte_i,
    input wire logic [31:0] req_addr_i,
    input wire logic [31:0] req_wdata_i,
    input wire logic done_o,
    input wire logic refused_o,
    input wire logic stall_o,
    input wire logic card_select_first_n_o,
    input wire logic card_select_second_n_o,
    input wire logic write_o,
    input wire logic [15:0] bus_o,
    input wire logic bus_oe_n_o,
    input wire logic [1:0] card_controller_ready_o,
    input wire logic [1:0] port_b_gpio_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    logic idle_req;
    assign idle_req = req_i && !stall_o && !done_o;
    sequence s_start;
        $fell(card_select_first_n_o && card_select_second_n_o) && !$past(stall_o);
    endsequence
    chk_refuse_off: assert property (idle_req && req_addr_i[31:28] == 4'h4 &&
        !system_config_two_i[5] |=> refused_o && card_select_first_n_o) else $error("region not refused");
    chk_select_two: assert property (idle_req && req_addr_i[31:28] == 4'h5 &&
        system_config_two_i[6] |-> ##[1:2] !card_select_second_n_o) else $error("select two missing");
    chk_field_half: assert property (s_start |-> !bus_oe_n_o && write_o == !req_write_i &&
        bus_o == {req_addr_i[25:16], req_byte_i ? 2'h0 : 2'h3, req_addr_i[27:26], 2'h3}) else $error("bad field");
    chk_addr_half: assert property (s_start |-> ##5 bus_o == req_addr_i[15:0] && write_o)
        else $error("bad address half");
    chk_wait_release: assert property (stall_o && card_select_first_n_o && card_select_second_n_o
        |-> bus_oe_n_o) else $error("bus held in wait");
    chk_ready_gate: assert property (!system_config_two_i[5] && !$past(system_config_two_i[5])
        |-> card_controller_ready_o[0]) else $error("ready not parked");
    chk_gpio_gate: assert property (system_config_two_i[6] && $past(system_config_two_i[6])
        |-> !port_b_gpio_o[1]) else $error("gpio not parked");
    chk_reg_data: assert property (s_start ##0 (req_addr_i[27:26] == 2'h3 && req_write_i && !req_byte_i)
        |-> ##10 bus_o == req_wdata_i[31:16] && !write_o ##5 bus_o == req_wdata_i[15:0]) else $error("bad data");
    chk_reg_done: assert property (s_start ##0 (req_addr_i[27:26] == 2'h3 && !req_byte_i) |-> ##21 done_o)
        else $error("late done");
endmodule : pcc_host_port_asserts
bind pcc_host_port pcc_host_port_asserts u_chk (.core_clk_i, .rst_n_i, .system_config_two_i, .req_i,
    .req_write_i, .req_byte_i, .req_addr_i, .req_wdata_i, .done_o, .refused_o, .stall_o, .card_select_first_n_o,
    .card_select_second_n_o, .write_o, .bus_o, .bus_oe_n_o, .card_controller_ready_o, .port_b_gpio_o);

// ### verif/tb.sv
// tb: self-checking bench for the card host port.
// assumes: card controller model on the far side, clk_en_i held high.
`timescale 1ns/1ps
module tb;
    import pcc_pkg::*;
    logic core_clk_i = 0, rst_n_i = 0, clk_en_i = 1, slow = 0, req_i = 0, req_write_i = 0, req_byte_i = 0;
    logic done_o, refused_o, stall_o, card_select_first_n_o, card_select_second_n_o, write_o, bus_oe_n_o;
    logic [6:0] system_config_two_i = 7'h00;
    logic [31:0] req_addr_i = 32'h0, req_wdata_i = 32'h0, rdata_o;
    logic [15:0] bus_o, bus_i, card_field;
    logic [1:0] port_b_i, card_controller_ready_o, port_b_gpio_o;
    int error_cnt = 0, checks_done = 0, n;
    always #5 core_clk_i = ~core_clk_i;
    pcc_host_port dut (.core_clk_i, .rst_n_i, .clk_en_i, .system_config_two_i, .req_i, .req_write_i, .req_byte_i,
        .req_addr_i, .req_wdata_i, .done_o, .refused_o, .stall_o, .rdata_o, .card_select_first_n_o,
        .card_select_second_n_o, .write_o, .bus_o, .bus_oe_n_o, .bus_i, .port_b_i, .card_controller_ready_o,
        .port_b_gpio_o);
    pcc_card_model card (.core_clk_i, .rst_n_i, .slow_i(slow), .sel_n_i(card_select_first_n_o &
        card_select_second_n_o), .oe_n_i(bus_oe_n_o), .host_bus_i(bus_o), .card_bus_o(bus_i), .ready_o(port_b_i),
        .field_o(card_field));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic acc(input logic wr, input logic byt, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        #1;
        n = 0;
        {req_write_i, req_byte_i, req_addr_i, req_wdata_i, req_i} = {wr, byt, a, d, 1'b1};
        do begin
            @(posedge core_clk_i);
            #1;
            n++;
        end while (done_o !== 1'b1 && n < 200);
        req_i = 0;
        chk("done", 1, done_o);
    endtask : acc
    task automatic refuse(input logic [31:0] a);
        @(posedge core_clk_i);
        #1;
        {req_addr_i, req_i} = {a, 1'b1};
        @(posedge core_clk_i);
        #1;
        req_i = 0;
        chk("refused", 1, refused_o);
        chk("selects", 2'h3, {card_select_first_n_o, card_select_second_n_o});
    endtask : refuse
    task automatic results();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    initial begin
        repeat (5000) @(posedge core_clk_i);
        error_cnt++;
        results();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge core_clk_i);
        #1 rst_n_i = 1;
        repeat (4) @(posedge core_clk_i);
        refuse(32'h4C00_0000);
        chk("gpio", 2'h3, port_b_gpio_o);
        system_config_two_i = 7'h60;
        for (int k = 0; k < 16; k++) begin
            acc(k[3], k[2], {k[2] ^ k[3] ? 4'h5 : 4'h4, 2'(k), 26'h0ABCDEF}, 32'h13579BDF + 32'(k));
            chk("cycles", k[2] ? 3 * PCC_PHASE_CYC + 2 : 4 * PCC_PHASE_CYC + 2, n);
            chk("field", {16'h0, 10'h0AB, k[2] ? PCC_SIZE_BYTE : PCC_SIZE_WORD, 2'(k), PCC_SLOT_FIXED}, {16'h0, card_field});
            if (!k[3]) begin
                chk("rdata", k[2] ? 32'h0000A55A : 32'hA55A3C96, rdata_o);
            end
        end
        slow = 1;
        acc(0, 0, 32'h4C00_0040, 32'h0);
        chk("reg cycles", 4 * PCC_PHASE_CYC + 2, n);
        for (int j = 0; j < 2; j++) begin
            slow = 0;
            @(posedge core_clk_i);
            #1 slow = 1;
            acc(j[0], 0, {j[0] ? 4'h5 : 4'h4, 28'h8000040}, 32'h2468ACE0);
            chk("stalled", 1, n > 4 * PCC_PHASE_CYC + 2);
            if (j == 0) begin
                chk("slow rdata", 32'hA55A3C96, rdata_o);
            end
        end
        slow = 0;
        system_config_two_i = 7'h20;
        refuse(32'h5000_0000);
        results();
    end
endmodule : tb
